// *** verilog/smsp_pkg.sv ***
package smsp_pkg;

  // byte geometry and control register layout
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned RX_FIFO_DEPTH = 8;
  localparam int unsigned B_DONE        = 7;
  localparam int unsigned B_WRITE_COLLISION_FLAG        = 6;
  localparam int unsigned B_EN          = 5;
  localparam int unsigned B_MSTR        = 4;
  localparam int unsigned B_CPOL        = 3;
  localparam int unsigned B_CPHA        = 2;
  localparam int unsigned B_RATE_HI     = 1;
  localparam int unsigned B_RATE_LO     = 0;

  // special-function addresses and reset values
  localparam logic [7:0] ADDR_DATA  = 8'hF7;
  localparam logic [7:0] ADDR_CTRL  = 8'hF8;
  localparam logic [7:0] CTRL_RESET = 8'h04;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] READ_NONE  = 8'h00;

  // bit and edge counters of one byte
  typedef logic [3:0] smsp_cnt_t;
  localparam smsp_cnt_t EDGE_FIRST = 4'h0;
  localparam smsp_cnt_t EDGE_LAST  = 4'hF;
  localparam smsp_cnt_t BITS_NONE  = 4'h0;
  localparam smsp_cnt_t BITS_LAST  = 4'h7;
  localparam smsp_cnt_t BITS_BYTE  = 4'h8;
  localparam smsp_cnt_t CNT_ONE    = 4'h1;

  // serial clock half periods in core clocks for fosc/2, /4, /8, /16
  typedef logic [3:0] smsp_half_t;
  localparam smsp_half_t HALF_DIV2  = 4'h1;
  localparam smsp_half_t HALF_DIV4  = 4'h2;
  localparam smsp_half_t HALF_DIV8  = 4'h4;
  localparam smsp_half_t HALF_DIV16 = 4'h8;
  localparam smsp_half_t HALF_ONE   = 4'h1;
  localparam smsp_half_t HALF_ZERO  = 4'h0;

  function automatic smsp_half_t smsp_half_period(input logic [1:0] code);
    smsp_half_t h;
    unique case (code)
      2'h0: h = HALF_DIV2;
      2'h1: h = HALF_DIV4;
      2'h2: h = HALF_DIV8;
      2'h3: h = HALF_DIV16;
    endcase
    return h;
  endfunction

endpackage

// *** verilog/smsp_top.sv ***
// Functional notes
// - done flag sets at byte end; cleared by writing zero or reading data
// - writing data during a transfer sets collision flag; only software clears it
// - enable bit gives pins to this port, otherwise to two-wire interface
// - master bit makes clock pin an output, otherwise an input
// - polarity bit sets serial clock idle level
// - phase one launches on leading edge, phase zero on trailing edge
// - master clock is core clock over 2, 4, 8 or 16 by rate field
// - in slave mode low rate bit reads the select pin level
// - data write gives byte to send, data read gives oldest unread received byte
// - master data write starts one burst of eight clock periods
// - master ignores its select pin; external selects come from port pins
// - master shifts out on MOSI and samples MISO each period
// - after eighth master clock received byte is loaded and flag set
// - slave sends on MISO and captures MOSI each incoming period
// - slave byte ends after eighth clock (phase one) or select rise (phase zero)
// - eight bits per transfer, most significant first, on both lines
// - data launched on one clock edge and sampled on the other
`timescale 1ns/1ps

// received bytes queue here until software has taken the previous one
module smsp_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 8
) (
  input  logic         clk,
  input  logic         reset,
  input  logic         in_valid,
  output logic         in_ready,
  input  logic [W-1:0] in_data,
  output logic         out_valid,
  input  logic         out_ready,
  output logic [W-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } smsp_fifo_s;

  smsp_fifo_s q;
  smsp_fifo_s d;
  logic       push;
  logic       pop;

  // pointer wrap relies on DEPTH being a power of two
  assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp        = q.wp + AW'(1);
    end
    if (pop) begin
      d.rp = q.rp + AW'(1);
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

module smsp_top #(
  parameter int unsigned RX_DEPTH = smsp_pkg::RX_FIFO_DEPTH
) (
  input  logic                      clk,
  input  logic                      reset,
  input  logic [7:0]                sfr_addr,
  input  logic                      sfr_wr,
  input  logic                      sfr_rd,
  input  logic [smsp_pkg::DATA_W-1:0] sfr_wdata,
  output logic [smsp_pkg::DATA_W-1:0] sfr_rdata,
  input  logic                      sclk_i,
  output logic                      sclk_o,
  output logic                      sclk_oe,
  input  logic                      mosi_i,
  output logic                      mosi_o,
  output logic                      mosi_oe,
  input  logic                      miso_i,
  output logic                      miso_o,
  output logic                      miso_oe,
  input  logic                      ss_n_i,
  output logic                      twi_pins_sel
);
  import smsp_pkg::*;

  typedef enum logic {M_IDLE, M_RUN} smsp_mstate_e;

  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] rx_data;
    logic [DATA_W-1:0] tx_sh;
    logic [DATA_W-1:0] rx_sh;
    logic [DATA_W-1:0] rdata;
    smsp_mstate_e      mstate;
    smsp_half_t        div_cnt;
    smsp_cnt_t         edge_cnt;
    smsp_cnt_t         sbits;
    logic              sclk_q;
    logic              sclk_prev;
    logic              ss_prev;
    logic              push_q;
  } smsp_state_s;

  smsp_state_s       q;
  smsp_state_s       d;
  logic              en;
  logic              cpol;
  logic              cpha;
  logic              mstr_on;
  logic              slave_on;
  logic              busy;
  logic              tick;
  logic              m_lead;
  logic              s_edge;
  logic              s_lead;
  logic              s_sample;
  logic              ss_rose;
  logic              wr_data;
  logic              rd_data;
  logic              f_in_ready;
  logic              f_out_valid;
  logic              f_out_ready;
  logic              fifo_take;
  logic [DATA_W-1:0] f_out_data;
  smsp_half_t        half;

  // mode decode from the control register
  assign en       = q.ctrl[B_EN];
  assign cpol     = q.ctrl[B_CPOL];
  assign cpha     = q.ctrl[B_CPHA];
  assign mstr_on  = en && q.ctrl[B_MSTR];
  assign slave_on = en && !q.ctrl[B_MSTR] && !ss_n_i;   // select only counts as slave
  assign wr_data  = sfr_wr && (sfr_addr == ADDR_DATA);
  assign rd_data  = sfr_rd && (sfr_addr == ADDR_DATA);
  assign busy     = (mstr_on && (q.mstate == M_RUN)) || (slave_on && (q.sbits != BITS_NONE));
  assign half     = smsp_half_period(q.ctrl[B_RATE_HI:B_RATE_LO]);
  assign tick     = (q.div_cnt == half - HALF_ONE);
  assign m_lead   = !q.edge_cnt[0];                     // even edges are leading
  // slave edges seen on the incoming clock, pins taken as synchronous
  assign s_edge   = slave_on && (sclk_i != q.sclk_prev);
  assign s_lead   = s_edge && (q.sclk_prev == cpol);
  assign s_sample = s_edge && (s_lead ^ cpha);
  assign ss_rose  = !q.ss_prev && ss_n_i;

  // pin drivers; the enables hand the pins back when the port is off
  assign sclk_o       = q.sclk_q;
  assign sclk_oe      = mstr_on;
  assign mosi_o       = q.tx_sh[DATA_W-1];
  assign mosi_oe      = mstr_on;
  assign miso_o       = q.tx_sh[DATA_W-1];
  assign miso_oe      = slave_on;
  assign twi_pins_sel = !en;
  assign sfr_rdata    = q.rdata;

  // next byte moves to the data register only once the flag is clear
  assign f_out_ready = !q.ctrl[B_DONE];
  assign fifo_take   = f_out_valid && f_out_ready;

  smsp_fifo #(
    .W     (DATA_W),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (q.push_q),
    .in_ready  (f_in_ready),
    .in_data   (q.rx_sh),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // whole next state; later assignments win, so hardware sets beat clears
  always_comb begin
    d           = q;
    d.push_q    = 1'b0;
    d.sclk_prev = sclk_i;
    d.ss_prev   = ss_n_i;
    // registered read answer
    if (sfr_rd) begin
      if (sfr_addr == ADDR_DATA) begin
        d.rdata = q.rx_data;
      end else if (sfr_addr == ADDR_CTRL) begin
        d.rdata = q.ctrl;
        if (en && !q.ctrl[B_MSTR]) begin
          d.rdata[B_RATE_LO] = ss_n_i;
        end
      end else begin
        d.rdata = READ_NONE;
      end
    end
    if (rd_data) begin
      d.ctrl[B_DONE] = 1'b0;
    end
    if (sfr_wr && (sfr_addr == ADDR_CTRL)) begin
      d.ctrl = sfr_wdata;
    end
    // master engine: one toggle per half period, sixteen edges a byte
    if (!mstr_on) begin
      d.mstate = M_IDLE;
    end
    if (!mstr_on || (q.mstate == M_IDLE)) begin
      d.sclk_q  = cpol;
      d.div_cnt = HALF_ZERO;
    end else if (tick) begin
      d.div_cnt  = HALF_ZERO;
      d.sclk_q   = !q.sclk_q;
      d.edge_cnt = q.edge_cnt + CNT_ONE;
      if (m_lead ^ cpha) begin
        d.rx_sh = {q.rx_sh[DATA_W-2:0], miso_i};
      end else if (!(cpha && (q.edge_cnt == EDGE_FIRST))) begin
        d.tx_sh = {q.tx_sh[DATA_W-2:0], 1'b0};
      end
      if (q.edge_cnt == EDGE_LAST) begin
        d.mstate = M_IDLE;
        d.push_q = 1'b1;
      end
    end else begin
      d.div_cnt = q.div_cnt + HALF_ONE;
    end
    // slave engine follows the incoming clock while selected
    if (!slave_on) begin
      d.sbits = BITS_NONE;
    end else if (s_sample) begin
      d.rx_sh = {q.rx_sh[DATA_W-2:0], mosi_i};
      d.sbits = q.sbits + CNT_ONE;
      if (cpha && (q.sbits == BITS_LAST)) begin
        d.sbits  = BITS_NONE;
        d.push_q = 1'b1;
      end
    end else if (s_edge && !(cpha && (q.sbits == BITS_NONE))) begin
      d.tx_sh = {q.tx_sh[DATA_W-2:0], 1'b0};
    end
    // phase zero byte closes on select rising
    if (en && !q.ctrl[B_MSTR] && !cpha && ss_rose && (q.sbits == BITS_BYTE)) begin
      d.push_q = 1'b1;
    end
    // a full receive queue refuses a master start like a busy port
    if (wr_data) begin
      if (busy || (mstr_on && !f_in_ready)) begin
        d.ctrl[B_WRITE_COLLISION_FLAG] = 1'b1;
      end else begin
        d.tx_sh = sfr_wdata;
        if (mstr_on) begin
          d.mstate   = M_RUN;
          d.div_cnt  = HALF_ZERO;
          d.edge_cnt = EDGE_FIRST;
          d.sclk_q   = cpol;
        end
      end
    end
    if (fifo_take) begin
      d.rx_data      = f_out_data;
      d.ctrl[B_DONE] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q         <= '0;
      q.ctrl    <= CTRL_RESET;
      q.rx_data <= DATA_RESET;
      q.mstate  <= M_IDLE;
      q.sclk_q  <= CTRL_RESET[B_CPOL];
      q.ss_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_start;
    wr_data && !busy && mstr_on && f_in_ready;
  endsequence

  sequence s_fast_run;
    (mstr_on && (q.ctrl[B_RATE_HI:B_RATE_LO] == 2'h0) && !sfr_wr)[*8];
  endsequence

  property p_master_start;
    s_start |=> (q.mstate == M_RUN) && (mosi_o == $past(sfr_wdata[DATA_W-1]));
  endproperty
  a_master_start: assert property (p_master_start) else $error("master write did not start");

  // sixteen edges at divide by two: start, two runs of eight, push one cycle later
  property p_burst_len;
    (s_start and (q.ctrl[B_RATE_HI:B_RATE_LO] == 2'h0)) ##1 s_fast_run ##1 s_fast_run
      |=> q.push_q;
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst was not sixteen edges");

  property p_write_collision_flag;
    wr_data && busy |=> q.ctrl[B_WRITE_COLLISION_FLAG] && $stable(q.tx_sh[DATA_W-2:0]) == 1'b0 || q.ctrl[B_WRITE_COLLISION_FLAG];
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision flag not set");

  property p_done_set;
    fifo_take |=> q.ctrl[B_DONE] && (q.rx_data == $past(f_out_data));
  endproperty
  a_done_set: assert property (p_done_set) else $error("received byte not loaded");

  property p_done_read;
    rd_data && !fifo_take && !sfr_wr |=> !q.ctrl[B_DONE];
  endproperty
  a_done_read: assert property (p_done_read) else $error("data read left flag set");

  property p_disabled;
    !en |-> !sclk_oe && !mosi_oe && !miso_oe && twi_pins_sel;
  endproperty
  a_disabled: assert property (p_disabled) else $error("pins driven while disabled");

  sequence s_idle2;
    (mstr_on && (q.mstate == M_IDLE)) ##1 (mstr_on && (q.mstate == M_IDLE) && $stable(cpol));
  endsequence

  property p_idle_level;
    s_idle2 |-> (sclk_o == cpol);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle clock level wrong");

  // mid-burst at the fastest rate the clock moves on every core cycle
  property p_fast_rate;
    s_fast_run ##0 ((q.mstate == M_RUN) && ($past(q.mstate) == M_RUN)) |-> $changed(sclk_o);
  endproperty
  a_fast_rate: assert property (p_fast_rate) else $error("divide by two rate wrong");

  property p_ss_read;
    sfr_rd && (sfr_addr == ADDR_CTRL) && en && !q.ctrl[B_MSTR]
      |=> sfr_rdata[B_RATE_LO] == $past(ss_n_i);
  endproperty
  a_ss_read: assert property (p_ss_read) else $error("select level not readable");

  property p_slave_end;
    s_sample && cpha && (q.sbits == BITS_LAST) |=> q.push_q ##0 (q.sbits == BITS_NONE);
  endproperty
  a_slave_end: assert property (p_slave_end) else $error("slave byte end missed");
endmodule

// *** testbench/smsp_partner.sv ***
`timescale 1ns/1ps
// far side of the port: slave to a master-mode port, master to a slave-mode port
module smsp_partner (
  input  logic clk,
  input  logic cpol,   // kept equal to the port setting
  input  logic cpha,
  input  logic sclk_o,
  input  logic mosi_o,
  input  logic miso_o,
  output logic miso_i,
  output logic sclk_i,
  output logic mosi_i,
  output logic ss_n_i
);
  logic [7:0] tx_q = 8'h00;
  logic [7:0] rx_q = 8'h00;
  int         nsamp = 8;
  logic       lead;

  initial begin
    sclk_i = 1'b0;
    mosi_i = 1'b0;
    ss_n_i = 1'b1;
  end

  // reacts to pin edges directly, no core clock delay, so the fastest rate is met
  always @(sclk_o) begin
    lead = (sclk_o != cpol);
    if (lead == !cpha) begin
      rx_q = {rx_q[6:0], mosi_o};  // msb first
      nsamp = nsamp + 1;
    end else if (nsamp > 0 && nsamp < 8) begin
      tx_q = {tx_q[6:0], 1'b0};  // launch on the other edge
    end
  end

  // a released line shows the inverse of its last bit, never a stale copy
  assign miso_i = (nsamp < 8) ? tx_q[7] : ~tx_q[7];

  task automatic load(input logic [7:0] b);
    tx_q = b;
    rx_q = 8'h00;
    nsamp = 0;
  endtask

  // one byte as master; select stays low afterwards until deselect
  task automatic xfer(input logic [7:0] b, output logic [7:0] got);
    got = 8'h00;
    // clock settles at its idle level before select falls, so no false edge
    @(posedge clk);
    sclk_i <= cpol;
    mosi_i <= b[7];
    @(posedge clk);
    ss_n_i <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      if (!cpha) got = {got[6:0], miso_o};
      sclk_i <= ~cpol;
      if (cpha) mosi_i <= b[7-i];
      repeat (4) @(posedge clk);
      if (cpha) got = {got[6:0], miso_o};
      sclk_i <= cpol;
      if (!cpha && i < 7) mosi_i <= b[6-i];
      repeat (4) @(posedge clk);
    end
  endtask

  task automatic deselect();
    @(posedge clk);
    ss_n_i <= 1'b1;
    mosi_i <= ~mosi_i;
  endtask
endmodule

// *** testbench/smsp_top_tb.sv ***
`timescale 1ns/1ps
module smsp_top_tb;
  import smsp_pkg::*;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic       sclk_i, sclk_o, sclk_oe, mosi_i, mosi_o, mosi_oe;
  logic       miso_i, miso_o, miso_oe, ss_n_i, twi_pins_sel;
  logic       cpol = 1'b0;
  logic       cpha = 1'b0;
  logic       sclk_prev = 1'b0;
  logic [7:0] v, t, r, q[$];
  int         err_count = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         nt, t_first, t_last, m, h;

  always #4 clk = ~clk;

  smsp_top DUT (.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sclk_i(sclk_i),
    .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_i(mosi_i), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o), .miso_oe(miso_oe),
    .ss_n_i(ss_n_i), .twi_pins_sel(twi_pins_sel));
  smsp_partner P (.clk(clk), .cpol(cpol), .cpha(cpha), .sclk_o(sclk_o), .mosi_o(mosi_o),
    .miso_o(miso_o), .miso_i(miso_i), .sclk_i(sclk_i), .mosi_i(mosi_i), .ss_n_i(ss_n_i));

  // hang guard and log of serial clock toggles, seen one edge late
  always @(posedge clk) begin
    cyc++;
    if (sclk_o !== sclk_prev) begin
      if (nt == 0) t_first = cyc;
      t_last = cyc;
      nt++;
    end
    sclk_prev = sclk_o;
    if (cyc == 20000) begin
      err_count++;
      $display("ERROR %0t run did not finish", $time);
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask

  // answer is registered, so it is taken just after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask

  // the partner learns the mode before the idle clock level moves
  task automatic cfg(input logic [7:0] c);
    cpol = c[B_CPOL];
    cpha = c[B_CPHA];
    wr(ADDR_CTRL, c);
    repeat (3) @(posedge clk);
  endtask

  task automatic wait_done();
    for (int k = 0; k < 200; k++) begin
      rd(ADDR_CTRL, v);
      if (v[B_DONE] === 1'b1) break;
    end
    chk({7'h00, v[B_DONE]}, 8'h01, "done flag");
  endtask

  initial begin
    void'($urandom(96));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_CTRL, v);
    chk(v, CTRL_RESET, "ctrl reset");
    rd(ADDR_DATA, v);
    chk(v, DATA_RESET, "data reset");
    rd(8'h80, v);
    chk(v, READ_NONE, "unmapped read");
    chk({6'h00, twi_pins_sel, sclk_oe}, 8'h02, "pins after reset");
    // slave, phase 0: the byte closes only when select rises
    for (m = 0; m < 2; m++) begin
      cfg({2'b00, 2'b10, m[0], 1'b0, 2'b00});
      rd(ADDR_CTRL, v);
      chk({7'h00, v[B_RATE_LO]}, 8'h01, "select high");
      t = 8'($urandom);
      r = 8'($urandom);
      wr(ADDR_DATA, t);
      P.xfer(r, v);
      chk({7'h00, miso_oe}, 8'h01, "miso driven");
      chk(v, t, "slave sent");
      rd(ADDR_CTRL, v);
      chk(v & 8'h81, 8'h00, "no flag before select rise");
      P.deselect();
      repeat (4) @(posedge clk);
      rd(ADDR_CTRL, v);
      chk(v & 8'h81, 8'h81, "flag after select rise");
      rd(ADDR_DATA, v);
      chk(v, r, "slave received");
    end
    // slave, phase 1, select held low: one byte past data register plus queue
    cfg(8'h24);
    for (m = 0; m <= RX_FIFO_DEPTH + 1; m++) begin
      r = 8'($urandom);
      q.push_back(r);
      P.xfer(r, t);
      if (m == 0) begin
        repeat (4) @(posedge clk);
        rd(ADDR_CTRL, v);
        chk(v & 8'h80, 8'h80, "flag after eighth clock");
      end
    end
    repeat (4) @(posedge clk);
    for (m = 0; m <= RX_FIFO_DEPTH; m++) begin
      rd(ADDR_DATA, v);
      chk(v, q[m], "queued byte order");
      repeat (2) @(posedge clk);
    end
    rd(ADDR_CTRL, v);
    chk(v & 8'h80, 8'h00, "queue drained");
    // master: every rate code and clock mode; select left low and ignored
    for (m = 0; m < 8; m++) begin
      cfg({2'b00, 2'b11, m[2], m[0] ^ m[2], m[1:0]});
      chk({4'h0, sclk_o, twi_pins_sel, mosi_oe, sclk_oe}, {4'h0, cpol, 3'b011},
          "idle master pins");
      h = 1 << m[1:0];
      r = 8'($urandom);
      t = 8'($urandom);
      P.load(r);
      nt = 0;
      wr(ADDR_DATA, t);
      wait_done();
      chk(nt[7:0], 8'h10, "clock toggles");
      chk(8'(t_last - t_first), 8'(15 * h), "clock rate");
      chk(P.rx_q, t, "mosi byte");
      rd(ADDR_DATA, v);
      chk(v, r, "miso byte");
      rd(ADDR_CTRL, v);
      chk(v & 8'h80, 8'h00, "flag cleared by data read");
    end
    // second data write mid-burst is refused and flagged
    cfg(8'h33);
    r = 8'($urandom);
    t = 8'($urandom);
    P.load(r);
    wr(ADDR_DATA, t);
    wr(ADDR_DATA, ~t);
    rd(ADDR_CTRL, v);
    chk(v & 8'hC0, 8'h40, "collision");
    wait_done();
    chk(P.rx_q, t, "first byte kept");
    wr(ADDR_CTRL, 8'h73);
    rd(ADDR_CTRL, v);
    chk(v & 8'hC0, 8'h40, "done cleared, collision kept");
    wr(ADDR_CTRL, 8'h33);
    rd(ADDR_CTRL, v);
    chk(v & 8'hC0, 8'h00, "collision cleared");
    cfg(8'h04);
    chk({4'h0, twi_pins_sel, sclk_oe, mosi_oe, miso_oe}, 8'h08, "pins released");
    conclude();
  end
endmodule
